// ---- rtl/ctu_serial.sv ----
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module ctu_serial
   import ctu_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Serial pins
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   output logic serial_out,
   input wire logic serial_in,
   // Event
   output logic serial_done_irq
);
   import ctu_pkg::*;

   // Half period of the internal serial clock in system cycles, minus one.
   function automatic logic [12:0] ctu_half(input logic [2:0] sel);
      unique case (sel)
         3'h0: ctu_half = 13'(CTU_HALF_0 - 1);
         3'h1: ctu_half = 13'(CTU_HALF_1 - 1);
         3'h2: ctu_half = 13'(CTU_HALF_2 - 1);
         3'h3: ctu_half = 13'(CTU_HALF_3 - 1);
         3'h4: ctu_half = 13'(CTU_HALF_4 - 1);
         default: ctu_half = 13'(CTU_HALF_5 - 1);
      endcase
   endfunction

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic aw_have;
      logic [5:0] aw_addr;
      logic w_have;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [2:0] sck_sel;
      logic [2:0] mode;
      logic start;
      logic [2:0] wcount;
      logic [1:0] wait_sel;
      ctu_state_t state;
      logic active;
      logic [7:0][7:0] buf_mem;
      logic [7:0] shifter;
      logic [7:0] rx;
      logic [2:0] bit_cnt;
      logic [2:0] word_idx;
      logic [12:0] div_cnt;
      logic sck_out;
      logic sck_oe;
      logic sout;
      logic irq;
      logic fresh;
      logic dummy;
      logic sck_s1;
      logic sck_s2;
      logic sck_s3;
      logic si_s1;
      logic si_s2;
   } ctu_regs_t;

   ctu_regs_t r_reg;
   ctu_regs_t r_next;
   logic do_start;
   logic do_abort;
   logic buf_wr;
   logic ext_clk;
   logic tx_mode;

   always_comb begin
      logic wr_go;
      logic fall;
      logic rise;
      logic nib;
      logic [2:0] last_bit;
      logic [7:0] rx_word;
      logic [5:0] ra;
      wr_go = 1'b0;
      fall = 1'b0;
      rise = 1'b0;
      nib = 1'b0;
      last_bit = 3'h7;
      rx_word = 8'h00;
      ra = 6'h00;
      do_start = 1'b0;
      do_abort = 1'b0;
      buf_wr = 1'b0;
      r_next = r_reg;
      r_next.irq = 1'b0;
      ext_clk = (r_reg.sck_sel == CTU_SCK_EXT);
      tx_mode = (r_reg.mode == CTU_MODE_TX8) || (r_reg.mode == CTU_MODE_TX4) || (r_reg.mode == CTU_MODE_TRX8);
      nib = (r_reg.mode == CTU_MODE_TX4) || (r_reg.mode == CTU_MODE_RX4);
      last_bit = nib ? 3'h3 : 3'h7;

      // Pin inputs pass two flops before the edge detector reads them.
      r_next.sck_s1 = sck_in;
      r_next.sck_s2 = r_reg.sck_s1;
      r_next.sck_s3 = r_reg.sck_s2;
      r_next.si_s1 = serial_in;
      r_next.si_s2 = r_reg.si_s1;

      // Write channel: address and data are taken in either order.
      if (s_axi_awvalid && r_reg.awready) begin
         r_next.aw_have = 1'b1;
         r_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r_reg.wready) begin
         r_next.w_have = 1'b1;
         r_next.wdata = s_axi_wdata;
         r_next.wstrb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         r_next.bvalid = 1'b0;
      end
      if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid) begin
         wr_go = 1'b1;
         r_next.aw_have = 1'b0;
         r_next.w_have = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp = CTU_RESP_OKAY;
      end

      // Serial engine.
      if (ext_clk) begin
         fall = r_reg.sck_s3 && !r_reg.sck_s2;
         rise = !r_reg.sck_s3 && r_reg.sck_s2;
      end else if (r_reg.state == CTU_RUN) begin
         if (r_reg.div_cnt == ctu_half(r_reg.sck_sel)) begin
            r_next.div_cnt = 13'h0000;
            fall = r_reg.sck_out;
            rise = !r_reg.sck_out;
            r_next.sck_out = !r_reg.sck_out;
         end else begin
            r_next.div_cnt = r_reg.div_cnt + 13'h0001;
         end
      end

      if (r_reg.state == CTU_RUN) begin
         if (fall && tx_mode) begin
            r_next.sout = r_reg.shifter[0];
         end
         if (rise) begin
            rx_word = {r_reg.si_s2, r_reg.rx[7:1]};
            r_next.rx = rx_word;
            r_next.shifter = {1'b0, r_reg.shifter[7:1]};
            r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
            if (r_reg.bit_cnt == last_bit) begin
               r_next.bit_cnt = 3'h0;
               if (!tx_mode || r_reg.mode == CTU_MODE_TRX8) begin
                  r_next.buf_mem[r_reg.word_idx] = nib ? {4'h0, rx_word[7:4]} : rx_word;
               end
               if (r_reg.word_idx == r_reg.wcount) begin
                  r_next.irq = 1'b1;
                  r_next.word_idx = 3'h0;
                  r_next.fresh = 1'b0;
                  r_next.shifter = r_reg.buf_mem[0];
                  if (!r_reg.start || r_reg.dummy) begin
                     r_next.state = CTU_IDLE;
                     r_next.active = 1'b0;
                     r_next.dummy = 1'b0;
                  end else if (ext_clk) begin
                     // No wait exists here; stale data goes out as a dummy pass.
                     r_next.dummy = !r_reg.fresh;
                  end else if (!r_reg.fresh) begin
                     r_next.state = CTU_WAIT;
                  end
               end else begin
                  r_next.word_idx = r_reg.word_idx + 3'h1;
                  r_next.shifter = r_reg.buf_mem[r_reg.word_idx + 3'h1];
               end
            end
         end
      end

      // Register writes.
      if (wr_go) begin
         if (r_reg.aw_addr[5:2] >= CTU_OFS_DATA[5:2]) begin
            if (r_reg.wstrb[0]) begin
               r_next.buf_mem[r_reg.aw_addr[4:2]] = r_reg.wdata[7:0];
               buf_wr = 1'b1;
               r_next.fresh = 1'b1;
               // Any buffer write counts, even beyond the word count, and one in the cycle the block ends too.
               if (r_next.state == CTU_WAIT) begin
                  r_next.state = CTU_RUN;
                  r_next.fresh = 1'b0;
                  r_next.shifter = (r_reg.aw_addr[4:2] == 3'h0) ? r_reg.wdata[7:0] : r_reg.buf_mem[0];
               end
            end
         end else if (r_reg.aw_addr == CTU_OFS_CTRL_ONE) begin
            if (r_reg.wstrb[0]) begin
               r_next.start = r_reg.wdata[CTU_BIT_START];
               if (r_reg.wdata[CTU_BIT_ABORT]) begin
                  do_abort = 1'b1;
                  r_next.state = CTU_IDLE;
                  r_next.active = 1'b0;
                  r_next.start = 1'b0;
                  r_next.dummy = 1'b0;
                  r_next.mode = r_reg.wdata[CTU_POS_MODE +: 3];
                  r_next.sck_sel = r_reg.wdata[CTU_POS_SCK +: 3];
               end else if (r_reg.state == CTU_IDLE) begin
                  r_next.mode = r_reg.wdata[CTU_POS_MODE +: 3];
                  r_next.sck_sel = r_reg.wdata[CTU_POS_SCK +: 3];
                  if (r_reg.wdata[CTU_BIT_START] && r_reg.wdata[CTU_POS_SCK +: 3] != CTU_SCK_UNUSED) begin
                     unique case (r_reg.wdata[CTU_POS_MODE +: 3])
                        CTU_MODE_TX8, CTU_MODE_TX4, CTU_MODE_TRX8, CTU_MODE_RX8, CTU_MODE_RX4: do_start = 1'b1;
                        default: do_start = 1'b0;
                     endcase
                  end
                  r_next.start = do_start;
               end
               if (do_start) begin
                  r_next.state = CTU_RUN;
                  r_next.active = 1'b1;
                  r_next.word_idx = 3'h0;
                  r_next.bit_cnt = 3'h0;
                  r_next.div_cnt = 13'h0000;
                  r_next.shifter = r_reg.buf_mem[0];
                  r_next.fresh = 1'b0;
                  r_next.sck_out = 1'b1;
               end
            end
         end else if (r_reg.aw_addr == CTU_OFS_CTRL_TWO) begin
            // Count may change while idle or during an automatic wait only.
            if (r_reg.wstrb[0] && r_reg.state != CTU_RUN) begin
               r_next.wcount = r_reg.wdata[CTU_POS_COUNT +: 3];
               r_next.wait_sel = r_reg.wdata[CTU_POS_WAIT +: 2];
            end
         end else begin
            r_next.bresp = CTU_RESP_SLVERR;
         end
      end
      r_next.sck_oe = (r_next.sck_sel != CTU_SCK_EXT);
      if (r_next.state == CTU_IDLE) begin
         r_next.sck_out = 1'b1;
      end

      // Read channel.
      if (s_axi_rvalid && s_axi_rready) begin
         r_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && r_reg.arready) begin
         ra = s_axi_araddr;
         r_next.rvalid = 1'b1;
         r_next.rresp = CTU_RESP_OKAY;
         r_next.rdata = 32'h0000_0000;
         if (ra[5:2] >= CTU_OFS_DATA[5:2]) begin
            r_next.rdata[7:0] = r_reg.buf_mem[ra[4:2]];
         end else if (ra == CTU_OFS_CTRL_ONE) begin
            // The abort bit always reads back as zero.
            r_next.rdata[7:0] = {r_reg.start, 1'b0, r_reg.mode, r_reg.sck_sel};
         end else if (ra == CTU_OFS_CTRL_TWO) begin
            r_next.rdata[7:0] = {3'h0, r_reg.wait_sel, r_reg.wcount};
         end else if (ra == CTU_OFS_STATUS) begin
            r_next.rdata[CTU_BIT_ACTIVE] = r_reg.active;
            r_next.rdata[CTU_BIT_SHIFT] = (r_reg.state == CTU_RUN);
         end else begin
            r_next.rresp = CTU_RESP_SLVERR;
         end
      end
      r_next.awready = !r_next.aw_have && !r_next.bvalid;
      r_next.wready = !r_next.w_have && !r_next.bvalid;
      r_next.arready = !r_next.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_reg <= '0;
         r_reg.sck_out <= 1'b1;
         r_reg.sout <= 1'b1;
         r_reg.sck_s1 <= 1'b1;
         r_reg.sck_s2 <= 1'b1;
         r_reg.sck_s3 <= 1'b1;
         r_reg.sck_oe <= 1'b1;
         r_reg.state <= CTU_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign s_axi_awready = r_reg.awready;
   assign s_axi_wready = r_reg.wready;
   assign s_axi_bvalid = r_reg.bvalid;
   assign s_axi_bresp = r_reg.bresp;
   assign s_axi_arready = r_reg.arready;
   assign s_axi_rvalid = r_reg.rvalid;
   assign s_axi_rresp = r_reg.rresp;
   assign s_axi_rdata = r_reg.rdata;
   assign sck_out = r_reg.sck_out;
   assign sck_oe = r_reg.sck_oe;
   assign serial_out = r_reg.sout;
   assign serial_done_irq = r_reg.irq;

   a_start_sets_active: assert property (@(posedge aclk) disable iff (!aresetn)
      do_start |=> r_reg.active && r_reg.state == CTU_RUN)
      else $error("Start write did not raise transfer active.");
   a_abort_ends_now: assert property (@(posedge aclk) disable iff (!aresetn)
      do_abort |=> !r_reg.active ##1 !r_reg.active)
      else $error("Abort did not end the transfer at once.");
   a_active_tracks_state: assert property (@(posedge aclk) disable iff (!aresetn)
      r_reg.active == (r_reg.state != CTU_IDLE))
      else $error("Transfer active disagrees with engine state.");
   a_sck_high_start: assert property (@(posedge aclk) disable iff (!aresetn)
      do_start && r_reg.wdata[CTU_POS_SCK +: 3] != CTU_SCK_EXT |=> r_reg.sck_out && r_reg.sck_oe)
      else $error("Serial clock not high at start.");
   a_wait_holds_clock: assert property (@(posedge aclk) disable iff (!aresetn)
      r_reg.state == CTU_WAIT && !buf_wr && !do_abort |=> r_reg.state == CTU_WAIT && $stable(r_reg.sck_out))
      else $error("Automatic wait released without a buffer write.");
   a_wait_release: assert property (@(posedge aclk) disable iff (!aresetn)
      r_reg.state == CTU_WAIT && buf_wr |=> r_reg.state == CTU_RUN)
      else $error("Buffer write did not release the wait.");
   a_tx_falling_edge: assert property (@(posedge aclk) disable iff (!aresetn)
      !ext_clk && tx_mode && r_reg.state == CTU_RUN && $fell(r_reg.sck_out) |-> r_reg.sout == $past(r_reg.shifter[0]))
      else $error("Transmit bit not presented at the falling edge.");
   a_irq_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
      serial_done_irq |-> r_reg.word_idx == 3'h0 ##1 !serial_done_irq)
      else $error("Done interrupt longer than one cycle.");
   // Software relies on these locks while a block is under way, so they are checked directly.
   a_idle_clock_high: assert property (@(posedge aclk) disable iff (!aresetn)
      r_reg.state == CTU_IDLE |-> r_reg.sck_out)
      else $error("Serial clock not high while idle.");
   a_count_locked: assert property (@(posedge aclk) disable iff (!aresetn)
      r_reg.state == CTU_RUN |=> $stable(r_reg.wcount))
      else $error("Word count changed while shifting.");
   a_mode_locked: assert property (@(posedge aclk) disable iff (!aresetn)
      r_reg.state != CTU_IDLE && !do_abort |=> $stable(r_reg.mode) && $stable(r_reg.sck_sel))
      else $error("Mode or clock select changed during a transfer.");
   a_halt_holds_data: assert property (@(posedge aclk) disable iff (!aresetn)
      r_reg.state != CTU_RUN |=> $stable(r_reg.sout))
      else $error("Serial output moved while not shifting.");
   a_dummy_then_end: assert property (@(posedge aclk) disable iff (!aresetn)
      serial_done_irq && $past(r_reg.dummy) |-> r_reg.state == CTU_IDLE)
      else $error("Dummy pass did not end the transfer.");
   a_abort_drops_start: assert property (@(posedge aclk) disable iff (!aresetn)
      do_abort |=> !r_reg.start)
      else $error("Abort left the start bit set.");
   a_ext_releases_pin: assert property (@(posedge aclk) disable iff (!aresetn)
      ext_clk |-> !r_reg.sck_oe)
      else $error("Serial clock pin driven with the external source.");
   a_int_drives_pin: assert property (@(posedge aclk) disable iff (!aresetn)
      !ext_clk |-> r_reg.sck_oe)
      else $error("Serial clock pin not driven with an internal source.");
   a_irq_ends_word: assert property (@(posedge aclk) disable iff (!aresetn)
      serial_done_irq |-> r_reg.bit_cnt == 3'h0 && $past(r_reg.word_idx) == r_reg.wcount)
      else $error("Done interrupt before the last counted word.");
endmodule

// ---- rtl/ctu_pkg.sv ----
// Function
// - Transfer-active status reads 1 during transfers.
// - Shift-active status reads 1 while shifting.
// - Transfer-active clears at end or abort.
// - Clock select: six internal rates, external.
// - Internal clock driven out, high at start.
// - Internal clock stops until buffer access.
// - Transmit data shifts on falling edge.
// - Receive data sampled on rising edge.
// - Four-bit words use low nibble, LSB first.
// - One to eight words per block.
// - Done interrupt after word count transferred.
// - Set mode, fill buffer, then start.
// - Next word loads after current LSB-first word.
// - Buffer-empty interrupt after final bit.
// - Internal clock waits for new data.
// - Any buffer write releases the wait.
// - Clearing start finishes current words first.
// - Abort ends transfer at once.
// - External clock without stop sends dummy, ends.
// - Abort bit clears itself.
// - Mode field decode with reserved codes.
// - Buffer used from lowest address upward.
package ctu_pkg;
   localparam logic [5:0] CTU_OFS_CTRL_ONE = 6'h00;
   localparam logic [5:0] CTU_OFS_CTRL_TWO = 6'h04;
   localparam logic [5:0] CTU_OFS_STATUS = 6'h08;
   localparam logic [5:0] CTU_OFS_DATA = 6'h20;
   localparam int CTU_BIT_START = 7;
   localparam int CTU_BIT_ABORT = 6;
   localparam int CTU_POS_MODE = 3;
   localparam int CTU_POS_SCK = 0;
   localparam int CTU_POS_WAIT = 3;
   localparam int CTU_POS_COUNT = 0;
   localparam int CTU_BIT_ACTIVE = 7;
   localparam int CTU_BIT_SHIFT = 6;
   localparam logic [2:0] CTU_SCK_UNUSED = 3'h6;
   localparam logic [2:0] CTU_SCK_EXT = 3'h7;
   localparam logic [2:0] CTU_MODE_TX8 = 3'h0;
   localparam logic [2:0] CTU_MODE_TX4 = 3'h2;
   localparam logic [2:0] CTU_MODE_TRX8 = 3'h4;
   localparam logic [2:0] CTU_MODE_RX8 = 3'h5;
   localparam logic [2:0] CTU_MODE_RX4 = 3'h6;
   localparam logic [1:0] CTU_RESP_OKAY = 2'h0;
   localparam logic [1:0] CTU_RESP_SLVERR = 2'h2;
   localparam logic [7:0] CTU_CTRL_RESET = 8'h00;
   localparam int CTU_FC_MHZ = 20;
   localparam int CTU_CLK_MHZ = 20;
   localparam int CTU_FC_PER_CLK = CTU_FC_MHZ / CTU_CLK_MHZ;
   localparam int CTU_HALF_0 = 4096 / CTU_FC_PER_CLK;
   localparam int CTU_HALF_1 = 128 / CTU_FC_PER_CLK;
   localparam int CTU_HALF_2 = 64 / CTU_FC_PER_CLK;
   localparam int CTU_HALF_3 = 32 / CTU_FC_PER_CLK;
   localparam int CTU_HALF_4 = 16 / CTU_FC_PER_CLK;
   localparam int CTU_HALF_5 = 8 / CTU_FC_PER_CLK;

   typedef enum logic [1:0] {CTU_IDLE, CTU_RUN, CTU_WAIT} ctu_state_t;
endpackage

// ---- verif/ctu_peer.sv ----
`timescale 1ns/1ps
module ctu_peer (
   // Device pins
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic serial_out,
   output logic sck_in,
   output logic serial_in,
   // Bench side
   input wire logic clr,
   output logic [63:0] rx,
   output int n_rx
);
   logic ext_sck = 1'b1;
   logic sck_pin;
   // The peer drives the pin whenever the device releases it, and holds it high outside its pulses.
   assign sck_pin = sck_oe ? sck_out : ext_sck;
   assign sck_in = sck_pin;
   initial begin
      rx = 64'h0000_0000_0000_0000;
      n_rx = 0;
      serial_in = 1'b0;
   end
   // Capture on the rising pin edge, half a period after the device launched the bit.
   always @(posedge sck_pin or posedge clr) begin
      if (clr) begin
         n_rx = 0;
      end else begin
         rx[n_rx] = serial_out;
         n_rx = n_rx + 1;
      end
   end
   // Receive data changes on every falling edge, so a stale value is never mistaken for fresh.
   // A clear restarts the pattern, so received words are known in advance.
   always @(negedge sck_pin or posedge clr) begin
      if (clr) begin
         serial_in <= 1'b0;
      end else begin
         serial_in <= ~serial_in;
      end
   end
   // The clock runs only inside frames; the small offset keeps pin edges off the system clock edge.
   task automatic pulse(input int n);
      #10;
      repeat (n) begin
         ext_sck = 1'b0;
         #200;
         ext_sck = 1'b1;
         #200;
      end
   endtask
endmodule

// ---- verif/ctu_serial_bench.sv ----
`timescale 1ns/1ps
module ctu_serial_bench;
   import ctu_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [5:0] s_axi_awaddr = 6'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b1;
   logic [5:0] s_axi_araddr = 6'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b1;
   logic sck_in, sck_out, sck_oe, serial_out, serial_in, serial_done_irq;
   logic clr = 1'b0;
   logic [63:0] rx;
   int n_rx;
   int n_fail = 0;
   int n_checks = 0;
   int n_irq = 0;
   logic [1:0] resp;
   logic [31:0] v;
   int base;
   int t0;
   always #25 aclk = ~aclk;
   always @(posedge aclk) if (serial_done_irq === 1'b1) n_irq <= n_irq + 1;
   ctu_serial dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck_in, .sck_out, .sck_oe,
      .serial_out, .serial_in, .serial_done_irq);
   ctu_peer peer (.sck_out, .sck_oe, .serial_out, .sck_in, .serial_in, .clr, .rx, .n_rx);

   function automatic logic [7:0] c1(input logic s, input logic [2:0] m, input logic [2:0] k);
      c1 = {s, 1'b0, m, k};
   endfunction
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // Both channels are offered together and each is released at the edge that takes it.
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
   endtask
   task automatic rd(input logic [5:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      resp = s_axi_rresp;
   endtask
   task automatic active(input logic exp);
      rd(CTU_OFS_STATUS);
      chk(v[CTU_BIT_ACTIVE], exp);
   endtask
   task automatic wait_irq();
      int i;
      i = 0;
      while (n_irq == base && i < 20000) begin
         @(posedge aclk);
         i++;
      end
      chk(64'(n_irq - base), 64'h1);
   endtask
   task automatic setup(input logic [7:0] d, input logic [2:0] cnt);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      base = n_irq;
      wr(CTU_OFS_DATA, d);
      wr(CTU_OFS_CTRL_TWO, {5'h00, cnt});
   endtask

   task automatic t_reset();
      active(1'b0);
      chk(resp, CTU_RESP_OKAY);
      chk(v[CTU_BIT_SHIFT], 1'b0);
      chk({sck_out, sck_oe, serial_out}, 3'h7);
      rd(6'h10);
      chk(resp, CTU_RESP_SLVERR);
      wr(6'h10, 8'h00);
      chk(resp, CTU_RESP_SLVERR);
      wr(CTU_OFS_CTRL_TWO, 8'h00);
      chk(resp, CTU_RESP_OKAY);
      $display("test reset done");
   endtask
   task automatic t_abort();
      setup(8'h55, 3'h0);
      wr(CTU_OFS_CTRL_ONE, c1(1'b1, CTU_MODE_TX8, 3'h0));
      active(1'b1);
      wr(CTU_OFS_CTRL_ONE, 8'h40 | c1(1'b0, CTU_MODE_TX4, 3'h5));
      active(1'b0);
      chk(sck_out, 1'b1);
      chk(64'(n_irq - base), 64'h0);
      rd(CTU_OFS_CTRL_ONE);
      chk(v, 64'(c1(1'b0, CTU_MODE_TX4, 3'h5)));
      $display("test abort done");
   endtask
   // Internal rates 1 to 5, one word each; the later starts also prove the abort bit cleared itself.
   task automatic t_rates();
      int h;
      int cyc;
      for (int k = 1; k <= 5; k++) begin
         h = 1 << (8 - k);
         setup(8'h35 ^ 8'(k), 3'h0);
         wr(CTU_OFS_CTRL_ONE, c1(1'b1, CTU_MODE_TX8, 3'(k)));
         t0 = int'($time / 50);
         wr(CTU_OFS_CTRL_ONE, c1(1'b0, CTU_MODE_TX8, 3'(k)));
         wait_irq();
         cyc = int'($time / 50) - t0;
         chk(64'((cyc >= 16 * h - 6) && (cyc <= 16 * h + 6)), 64'h1);
         chk({rx[7:0], 8'(n_rx)}, {8'h35 ^ 8'(k), 8'h08});
         active(1'b0);
      end
      $display("test rates done");
   endtask
   task automatic t_wait();
      setup(8'hA5, 3'h1);
      rd(CTU_OFS_CTRL_TWO);
      chk(v, 64'h1);
      wr(CTU_OFS_DATA + 6'h04, 8'h3C);
      wr(CTU_OFS_CTRL_ONE, c1(1'b1, CTU_MODE_TX8, 3'h5));
      wait_irq();
      chk(rx[15:0], 16'h3CA5);
      repeat (40) @(posedge aclk);
      active(1'b1);
      chk({v[CTU_BIT_SHIFT], sck_out, 8'(n_rx)}, {2'b01, 8'h10});
      base = n_irq;
      wr(CTU_OFS_DATA, 8'h0F);
      wr(CTU_OFS_CTRL_ONE, c1(1'b0, CTU_MODE_TX8, 3'h5));
      wait_irq();
      chk(rx[31:16], 16'h3C0F);
      active(1'b0);
      $display("test wait done");
   endtask
   task automatic t_tx4();
      setup(8'hD6, 3'h0);
      wr(CTU_OFS_CTRL_ONE, c1(1'b1, CTU_MODE_TX4, 3'h5));
      wr(CTU_OFS_CTRL_ONE, c1(1'b0, CTU_MODE_TX4, 3'h5));
      wait_irq();
      chk({rx[3:0], 8'(n_rx)}, {4'h6, 8'h04});
      active(1'b0);
      $display("test nibble done");
   endtask
   // The peer's input restarts at 1, 0, 1, 0 after every clear, least significant bit first.
   task automatic t_rx();
      setup(8'hFF, 3'h0);
      wr(CTU_OFS_CTRL_ONE, c1(1'b1, CTU_MODE_RX4, 3'h5));
      wr(CTU_OFS_CTRL_ONE, c1(1'b0, CTU_MODE_RX4, 3'h5));
      wait_irq();
      rd(CTU_OFS_DATA);
      chk(v, 64'h05);
      setup(8'h96, 3'h0);
      wr(CTU_OFS_CTRL_ONE, c1(1'b1, CTU_MODE_TRX8, 3'h5));
      wr(CTU_OFS_CTRL_ONE, c1(1'b0, CTU_MODE_TRX8, 3'h5));
      wait_irq();
      chk(rx[7:0], 8'h96);
      rd(CTU_OFS_DATA);
      chk(v, 64'h55);
      active(1'b0);
      $display("test receive done");
   endtask
   task automatic t_ext();
      setup(8'h96, 3'h0);
      wr(CTU_OFS_CTRL_ONE, c1(1'b1, CTU_MODE_TX8, CTU_SCK_EXT));
      chk(sck_oe, 1'b0);
      peer.pulse(8);
      wait_irq();
      chk(rx[7:0], 8'h96);
      peer.pulse(8);
      repeat (10) @(posedge aclk);
      active(1'b0);
      chk(64'(n_rx), 64'h10);
      $display("test external done");
   endtask
   task automatic t_reserved();
      logic [7:0] codes [4];
      codes = '{c1(1'b1, 3'h1, 3'h5), c1(1'b1, 3'h3, 3'h5), c1(1'b1, 3'h7, 3'h5), c1(1'b1, 3'h0, CTU_SCK_UNUSED)};
      foreach (codes[i]) begin
         wr(CTU_OFS_CTRL_ONE, codes[i]);
         active(1'b0);
         wr(CTU_OFS_CTRL_ONE, 8'h00);
      end
      $display("test reserved done");
   endtask

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge aclk);
      n_fail++;
      $display("Error at %0t: watchdog expired", $time);
      close_out();
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_abort();
      t_rates();
      t_wait();
      t_tx4();
      t_rx();
      t_ext();
      t_reserved();
      close_out();
   end
endmodule
